//--- common/lwd_pkg.sv
// constants, register map and types for the LED PWM driver
// How it works
// R1: own 8-bit PWM per output, 97 kHz
// R2: duty runs 0 to 255/256, linear
// R3: group PWM dims pwm+group outputs at 190 Hz
// R4: blink period 1/24 s up to 10.7 s
// R5: per output: off, on, pwm, pwm+group
// R6: reset clears every output brightness
// R7: reset sets group brightness to maximum
// R8: outputs update on ack or stop
// R9: active-low enable pin gates all outputs
// R10: own address taken from seven pins
// R11: group and three sub addresses, each enableable
// R12: soft reset call restores all defaults
// R13: pattern byte enables chosen outputs
// R14: all timing from 25 MHz tick
// R15: bus inputs filtered before use
// R16: bus slave up to 1 MHz
// R17: both controls: individual gated by group
// R18: power-on reset, outputs off, no glitch
package lwd_pkg;
	localparam int LWD_NLED = 24;
	localparam int LWD_NREG = 39;
	localparam int LWD_AW = 8;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_MODE = 6'h00;
	localparam logic [5:0] IDX_GRPPWM = 6'h01;
	localparam logic [5:0] IDX_GRPFREQ = 6'h02;
	localparam logic [5:0] IDX_PATTERN = 6'h03;
	localparam logic [5:0] IDX_STATE0 = 6'h04;
	localparam logic [5:0] IDX_PWM0 = 6'h0a;
	localparam logic [5:0] IDX_GRPADDR = 6'h22;
	localparam logic [5:0] IDX_SUB0 = 6'h23;
	localparam logic [5:0] IDX_STATUS = 6'h26;
	// mode register bits
	localparam int MB_GRP_EN = 0;
	localparam int MB_SUB0_EN = 1;
	localparam int MB_BLINK = 4;
	localparam int MB_ACK_UPD = 5;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] GRPPWM_RST = 8'hff;
	localparam logic [7:0] GRPADDR_RST = 8'he0;
	localparam logic [7:0] SUB0_RST = 8'he2;
	localparam logic [7:0] SUB1_RST = 8'he4;
	localparam logic [7:0] SUB2_RST = 8'he8;
	// bus call codes
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [7:0] SOFT_RESET_CALL = 8'h06;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// output state codes
	localparam logic [1:0] LS_OFF = 2'h0;
	localparam logic [1:0] LS_ON = 2'h1;
	localparam logic [1:0] LS_PWM = 2'h2;
	localparam logic [1:0] LS_GRP = 2'h3;
	// timing
	localparam int PCLK_HZ = 100_000_000;
	localparam int OSC_HZ = 25_000_000;
	localparam int OSC_DIV = PCLK_HZ / OSC_HZ;
	localparam int PWM_STEPS = 256;
	localparam int DIM_HZ = 190;
	localparam int BLINK_HZ = 24;
	localparam int DIM_TICKS = OSC_HZ / (DIM_HZ * PWM_STEPS);
	localparam int BLINK_TICKS = OSC_HZ / (BLINK_HZ * PWM_STEPS);
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_AACK = 5'h04,
		ST_DATA = 5'h08,
		ST_DACK = 5'h10
	} lwd_i2c_t;
	function automatic logic [LWD_NREG-1:0][7:0] lwd_defaults();
		logic [LWD_NREG-1:0][7:0] d;
		d = '0;
		d[IDX_MODE] = MODE_RST;
		d[IDX_GRPPWM] = GRPPWM_RST;
		d[IDX_GRPADDR] = GRPADDR_RST;
		d[IDX_SUB0] = SUB0_RST;
		d[IDX_SUB0+6'h01] = SUB1_RST;
		d[IDX_SUB0+6'h02] = SUB2_RST;
		return d;
	endfunction : lwd_defaults
endpackage : lwd_pkg

//--- rtl/lwd_top.sv
// LED PWM driver core: bus slave, PWM engines, output gating
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lwd_top #(
	parameter int BLINK_BASE = lwd_pkg::BLINK_TICKS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lwd_pkg::LWD_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// pins
	input wire logic [6:0] addr_pins,
	input wire logic oe_n,
	output logic [lwd_pkg::LWD_NLED-1:0] led_on
);
	import lwd_pkg::*;

	typedef struct packed {
		logic [LWD_NREG-1:0][7:0] act;
		logic [LWD_NREG-1:0][7:0] shd;
		logic [1:0] presc;
		logic [7:0] icnt;
		logic [7:0] gcnt;
		logic [12:0] gsub;
		logic [7:0] gmul;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] oe_s;
		logic scl_f;
		logic sda_f;
		logic scl_p;
		logic sda_p;
		logic oe_n_f;
		logic [2:0][6:0] apin_s;
		logic [6:0] apin_f;
		lwd_i2c_t ist;
		logic [3:0] bitc;
		logic [7:0] shreg;
		logic [5:0] ptr;
		logic first;
		logic gcall;
		logic swr_pend;
		logic sda_oe_n;
		logic [LWD_NLED-1:0] led;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} lwd_st_t;

	function automatic lwd_st_t lwd_rst();
		lwd_st_t s;
		s = '0;
		s.act = lwd_defaults();
		s.shd = lwd_defaults();
		s.scl_s = 3'h7;
		s.sda_s = 3'h7;
		s.oe_s = 3'h7;
		s.scl_f = 1'b1;
		s.sda_f = 1'b1;
		s.scl_p = 1'b1;
		s.sda_p = 1'b1;
		s.oe_n_f = 1'b1;
		s.ist = ST_IDLE;
		s.sda_oe_n = 1'b1;
		return s;
	endfunction : lwd_rst

	lwd_st_t r;
	lwd_st_t n;
	logic tick;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic ack_mode;
	logic blink;
	logic apb_wr;
	logic hit_gc;
	logic hit_any;
	logic [6:0] adr;
	logic [5:0] aidx;
	logic aerr;
	logic [7:0] status;
	logic [12:0] sub_lim;
	logic [7:0] mul_lim;
	logic [LWD_NLED-1:0] led_want;

	// per-output state decode and waveform select
	for (genvar gi = 0; gi < LWD_NLED; gi++) begin : g_led
		localparam int SI = int'(IDX_STATE0) + gi / 4;
		localparam int PI = int'(IDX_PWM0) + gi;
		logic [1:0] ls;
		logic ind;
		logic grp;
		logic pat;
		assign ls = r.act[SI][2*(gi%4)+:2];
		assign ind = r.icnt < r.act[PI]; // R1 R2
		assign grp = r.gcnt < r.act[IDX_GRPPWM]; // R3 R4
		assign pat = (r.act[IDX_PATTERN] == 8'h00) | r.act[IDX_PATTERN][gi%8]; // R13
		assign led_want[gi] = pat & ((ls == LS_ON) | ((ls == LS_PWM) & ind) | ((ls == LS_GRP) & ind & grp)); // R5 R17
	end

	always_comb begin
		n = r;
		tick = r.presc == 2'(OSC_DIV - 1);
		scl_rise = r.scl_f & ~r.scl_p;
		scl_fall = ~r.scl_f & r.scl_p;
		i2c_start = r.scl_f & r.scl_p & r.sda_p & ~r.sda_f;
		i2c_stop = r.scl_f & r.scl_p & ~r.sda_p & r.sda_f;
		ack_mode = r.act[IDX_MODE][MB_ACK_UPD];
		blink = r.act[IDX_MODE][MB_BLINK];
		apb_wr = psel & penable & r.pready & pwrite;
		adr = r.shreg[7:1];
		hit_gc = adr == GEN_CALL_ADDR;
		hit_any = hit_gc | (adr == r.apin_f); // R10
		hit_any = hit_any | (r.act[IDX_MODE][MB_GRP_EN] & (adr == r.act[IDX_GRPADDR][7:1])); // R11
		for (int k = 0; k < 3; k++) begin
			hit_any = hit_any | (r.act[IDX_MODE][MB_SUB0_EN+k] & (adr == r.act[int'(IDX_SUB0)+k][7:1])); // R11
		end
		aidx = paddr[7:2];
		aerr = (paddr[1:0] != 2'h0) | (aidx > IDX_STATUS);
		status = {r.ptr, r.swr_pend, r.ist != ST_IDLE};
		sub_lim = blink ? 13'(BLINK_BASE - 1) : 13'(DIM_TICKS - 1);
		mul_lim = blink ? r.act[IDX_GRPFREQ] : 8'h00;
		// input synchronisers and agreement filters
		n.scl_s = {r.scl_s[1:0], scl_in};
		n.sda_s = {r.sda_s[1:0], sda_in};
		n.oe_s = {r.oe_s[1:0], oe_n};
		n.apin_s = {r.apin_s[1:0], addr_pins};
		if (r.scl_s[1] == r.scl_s[2]) begin
			n.scl_f = r.scl_s[2]; // R15
		end
		if (r.sda_s[1] == r.sda_s[2]) begin
			n.sda_f = r.sda_s[2]; // R15
		end
		if (r.oe_s[1] == r.oe_s[2]) begin
			n.oe_n_f = r.oe_s[2];
		end
		n.apin_f = (r.apin_s[1] & r.apin_s[2]) | (r.apin_f & (r.apin_s[1] ^ r.apin_s[2]));
		n.scl_p = r.scl_f;
		n.sda_p = r.sda_f;
		// oscillator tick and pwm counters
		n.presc = tick ? 2'h0 : r.presc + 2'h1; // R14
		if (tick) begin
			n.icnt = r.icnt + 8'h01; // R1
			if (r.gsub >= sub_lim) begin
				n.gsub = 13'h0000;
				if (r.gmul >= mul_lim) begin
					n.gmul = 8'h00;
					n.gcnt = r.gcnt + 8'h01; // R3 R4
				end else begin
					n.gmul = r.gmul + 8'h01;
				end
			end else begin
				n.gsub = r.gsub + 13'h0001;
			end
		end
		// serial slave
		if ((r.ist == ST_ADDR || r.ist == ST_DATA) && scl_rise && r.bitc < BYTE_BITS) begin
			n.shreg = {r.shreg[6:0], r.sda_f};
			n.bitc = r.bitc + 4'h1; // R16
		end
		if (i2c_stop) begin
			n.ist = ST_IDLE;
			n.sda_oe_n = 1'b1;
			if (!ack_mode) begin
				n.act = r.shd; // R8
			end
			if (r.swr_pend) begin
				n.act = lwd_defaults(); // R12 R6 R7
				n.shd = lwd_defaults(); // R12
				n.ptr = 6'h00;
				n.swr_pend = 1'b0;
			end
		end else if (i2c_start) begin
			n.ist = ST_ADDR;
			n.bitc = 4'h0;
			n.sda_oe_n = 1'b1;
			n.first = 1'b1;
			n.gcall = 1'b0;
		end else begin
			case (r.ist)
				ST_IDLE: begin
					n.sda_oe_n = 1'b1;
				end
				ST_ADDR: begin
					if (scl_fall && r.bitc == BYTE_BITS) begin
						if (!r.shreg[0] && hit_any) begin
							n.ist = ST_AACK;
							n.sda_oe_n = 1'b0; // R10 R11
							n.gcall = hit_gc;
						end else begin
							n.ist = ST_IDLE; // R16
						end
					end
				end
				ST_DATA: begin
					if (scl_fall && r.bitc == BYTE_BITS) begin
						n.ist = ST_DACK;
						n.sda_oe_n = 1'b0;
						if (r.gcall) begin
							if (r.shreg == SOFT_RESET_CALL) begin
								n.swr_pend = 1'b1; // R12
							end
						end else if (r.first) begin
							n.ptr = r.shreg[5:0];
							n.first = 1'b0;
						end else begin
							if (r.ptr < IDX_STATUS) begin
								n.shd[r.ptr] = r.shreg;
								if (ack_mode) begin
									n.act[r.ptr] = r.shreg; // R8
								end
							end
							n.ptr = (r.ptr >= IDX_STATUS - 6'h01) ? 6'h00 : r.ptr + 6'h01;
						end
					end
				end
				ST_AACK, ST_DACK: begin
					if (scl_fall) begin
						n.ist = ST_DATA;
						n.bitc = 4'h0;
						n.sda_oe_n = 1'b1;
					end
				end
				default: begin
					n.ist = ST_IDLE;
					n.sda_oe_n = 1'b1;
				end
			endcase
		end
		// apb slave, one wait-free access cycle
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.pslverr = aerr;
			n.prdata = 32'h0000_0000;
			if (!aerr && !pwrite) begin
				n.prdata[7:0] = (aidx == IDX_STATUS) ? status : r.act[aidx];
			end
		end else begin
			n.pready = 1'b0;
			n.pslverr = 1'b0;
		end
		if (apb_wr && !r.pslverr && aidx < IDX_STATUS) begin
			n.act[aidx] = pwdata[7:0];
			n.shd[aidx] = pwdata[7:0];
		end
		n.led = led_want & {LWD_NLED{~r.oe_n_f}}; // R9
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= lwd_rst(); // R18 R6 R7
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign sda_out = 1'b0;
	assign sda_oe_n = r.sda_oe_n;
	assign led_on = r.led;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	oe_gate_a: assert property (r.oe_n_f |=> led_on == '0) else $error("outputs not gated by enable pin"); // R9
	off_state_a: assert property (r.act[IDX_STATE0][1:0] == LS_OFF |=> !led_on[0]) else $error("off output lit"); // R5
	on_state_a: assert property ((r.act[IDX_STATE0][1:0] == LS_ON) && !r.oe_n_f && r.act[IDX_PATTERN] == 8'h00
		|=> led_on[0]) else $error("on output dark"); // R5
	pwm_duty_a: assert property ((r.act[IDX_STATE0][1:0] == LS_PWM) && !r.oe_n_f && r.act[IDX_PATTERN] == 8'h00
		|=> led_on[0] == $past(r.icnt < r.act[IDX_PWM0])) else $error("individual duty wrong"); // R1 R2
	grp_mix_a: assert property ((r.act[IDX_STATE0][1:0] == LS_GRP) && !r.oe_n_f && r.act[IDX_PATTERN] == 8'h00
		|=> led_on[0] == $past((r.icnt < r.act[IDX_PWM0]) && (r.gcnt < r.act[IDX_GRPPWM])))
		else $error("group mix wrong"); // R17
	tick_period_a: assert property (tick |=> !tick [*3] ##1 tick) else $error("tick period not four"); // R14
	icnt_step_a: assert property (tick |=> r.icnt == 8'($past(r.icnt) + 8'h01)) else $error("pwm counter step"); // R1
	dim_step_a: assert property (tick && !blink && r.gsub == 13'(DIM_TICKS - 1) && !apb_wr
		|=> r.gcnt == 8'($past(r.gcnt) + 8'h01)) else $error("dim step missing"); // R3
	filter_a: assert property ($changed(r.scl_f) |-> $past(r.scl_s[1] == r.scl_s[2])) else $error("scl unfiltered"); // R15
	ack_drive_a: assert property ((r.ist == ST_AACK || r.ist == ST_DACK) |-> !sda_oe_n) else $error("ack not driven"); // R11
	read_nack_a: assert property ((r.ist == ST_ADDR) && scl_fall && r.bitc == BYTE_BITS && r.shreg[0]
		|=> r.ist == ST_IDLE && sda_oe_n) else $error("read address acked"); // R16
	stop_commit_a: assert property (i2c_stop && !ack_mode && !r.swr_pend && !apb_wr
		|=> r.act[IDX_PWM0] == $past(r.shd[IDX_PWM0])) else $error("stop commit lost"); // R8
	soft_reset_a: assert property (i2c_stop && r.swr_pend && !apb_wr
		|=> r.act[IDX_PWM0] == 8'h00 && r.act[IDX_GRPPWM] == GRPPWM_RST && !r.swr_pend)
		else $error("soft reset incomplete"); // R12
	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb ready timing");

	soft_reset_c: cover property (i2c_stop && r.swr_pend);
	addr_ack_c: cover property (r.ist == ST_AACK && !r.gcall);
	grp_led_c: cover property ((r.act[IDX_STATE0][1:0] == LS_GRP) ##1 led_on[0]);
	ack_update_c: cover property (ack_mode && r.ist == ST_DACK);
endmodule : lwd_top
`default_nettype wire

//--- tb/lwd_bus_model.sv
// serial bus master model for the two-wire port of the LED driver
`timescale 1ns/1ps
`default_nettype none
module lwd_bus_model (
	// clock
	input wire logic pclk,
	// bus wires
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// half bit of 50 pclk keeps scl at 1 MHz
	localparam int HALF = 50;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic h(input int n);
		repeat (n) @(posedge pclk);
	endtask : h
	task automatic start();
		sda_drv <= 1'b0;
		h(HALF);
		scl <= 1'b0;
		h(HALF / 2);
	endtask : start
	task automatic stop();
		sda_drv <= 1'b0;
		h(HALF / 2);
		scl <= 1'b1;
		h(HALF);
		sda_drv <= 1'b1;
		h(HALF);
	endtask : stop
	// msb first, then an ack slot with sda released to the pull-up
	task automatic put(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_drv <= (i == 0) ? 1'b1 : b[i-1];
			h(HALF / 2);
			scl <= 1'b1;
			h(HALF);
			ack = (sda_line === 1'b0);
			scl <= 1'b0;
			h(HALF / 2);
		end
	endtask : put
endmodule : lwd_bus_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the LED PWM driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb;
	import lwd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oe_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, sda_out, sda_oe_n, scl, sda_m, ack;
	logic [6:0] addr_pins = 7'h15;
	logic [23:0] led_on;
	wire logic sda_w;
	int errors = 0;
	int checked = 0;
	int cnt [4];
	// open-drain wire with pull-up
	assign sda_w = sda_m & (sda_oe_n | sda_out);
	always #5 pclk = ~pclk;
	lwd_top #(.BLINK_BASE(4)) i_lwd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pins(addr_pins),
		.oe_n(oe_n), .led_on(led_on));
	lwd_bus_model i_lwd_bus_model (.pclk(pclk), .sda_line(sda_w), .scl(scl), .sda_drv(sda_m));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			finish_test();
		end
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h00_0000, d}, r, e);
		`CHK(e, 1'b0)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK(r, {24'h00_0000, x})
		`CHK(e, xe)
	endtask : rd
	// lit cycles of outputs 0..3 over one 1024-cycle pwm period
	task automatic lit(input int a, input int b, input int c, input int d);
		cnt = '{default: 0};
		repeat (16) @(posedge pclk);
		repeat (1024) begin
			@(posedge pclk);
			for (int k = 0; k < 4; k++) cnt[k] += (led_on[k] === 1'b1);
		end
		`CHK(cnt[0], a)
		`CHK(cnt[1], b)
		`CHK(cnt[2], c)
		`CHK(cnt[3], d)
	endtask : lit
	task automatic bus(input logic [7:0] b, input logic x);
		i_lwd_bus_model.put(b, ack);
		`CHK(ack, x)
	endtask : bus
	initial begin
		logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h28, 8'h88, 8'h8c, 8'h94};
		logic [7:0] rv [8] = '{MODE_RST, GRPPWM_RST, 8'h00, 8'h00, 8'h00, GRPADDR_RST, SUB0_RST, SUB2_RST};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		foreach (ra[i]) rd(ra[i], rv[i], 1'b0);
		rd(8'h9c, 8'h00, 1'b1);
		$display("test reset values done");
		wr(8'h10, 8'he4);
		wr(8'h2c, 8'h80);
		wr(8'h30, 8'hff);
		wr(8'h34, 8'h80);
		wr(8'h04, 8'h00);
		lit(0, 1024, 1020, 0);
		wr(8'h04, 8'hff);
		lit(0, 1024, 1020, 512);
		oe_n <= 1'b1;
		lit(0, 0, 0, 0);
		oe_n <= 1'b0;
		wr(8'h0c, 8'h02);
		lit(0, 1024, 0, 0);
		wr(8'h0c, 8'h00);
		$display("test outputs done");
		i_lwd_bus_model.start();
		bus(8'h2a, 1'b1);
		bus(8'h0a, 1'b1);
		bus(8'h5a, 1'b1);
		rd(8'h28, 8'h00, 1'b0);
		i_lwd_bus_model.stop();
		rd(8'h28, 8'h5a, 1'b0);
		rd(8'h98, 8'h2c, 1'b0);
		// update on ack: byte lands before stop
		wr(8'h00, 8'h21);
		i_lwd_bus_model.start();
		bus(8'h2a, 1'b1);
		bus(8'h0b, 1'b1);
		bus(8'h77, 1'b1);
		rd(8'h2c, 8'h77, 1'b0);
		i_lwd_bus_model.stop();
		i_lwd_bus_model.start();
		bus(8'h2c, 1'b0);
		i_lwd_bus_model.stop();
		i_lwd_bus_model.start();
		bus(8'he0, 1'b1);
		i_lwd_bus_model.stop();
		i_lwd_bus_model.start();
		bus(8'he2, 1'b0);
		i_lwd_bus_model.stop();
		i_lwd_bus_model.start();
		bus(8'h00, 1'b1);
		bus(SOFT_RESET_CALL, 1'b1);
		i_lwd_bus_model.stop();
		rd(8'h28, 8'h00, 1'b0);
		rd(8'h10, 8'h00, 1'b0);
		rd(8'h00, MODE_RST, 1'b0);
		$display("test serial bus done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
